// ==== common/cspop_map.svh ====
// constants of the service-schedule pop unit
`ifndef CSPOP_MAP_SVH
`define CSPOP_MAP_SVH
`define CSPOP_OPCODE        6'h09
`define CSPOP_OP_HI         31
`define CSPOP_OP_LO         26
`define CSPOP_RD_HI         25
`define CSPOP_RD_LO         20
`define CSPOP_SUB_HI        19
`define CSPOP_SUB_LO        17
`define CSPOP_SUB_POP       3'h0
`define CSPOP_RSB_HI        5
`define CSPOP_RSB_LO        0
`define CSPOP_TGT_W         14
`define CSPOP_CFG_BASE_HI   11
`define CSPOP_CFG_BASE_LO   8
`define CSPOP_ADDR_W        19
`define CSPOP_STAT_BIT      4
`define CSPOP_RD_HW_LIMIT   6'h20
`define CSPOP_SB_DEPTH      16384
`endif

// ==== common/cspop_pkg.sv ====
// types of the service-schedule pop unit
package cspop_pkg;
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] rsb_value;
  } cspop_issue_t;

  typedef struct packed {
    logic        valid;
    logic [5:0]  rd;
    logic [15:0] conn_id;
  } cspop_wb_t;

  typedef enum logic [2:0] {
    CSPOP_IDLE = 3'b001,
    CSPOP_READ = 3'b010,
    CSPOP_DONE = 3'b100
  } cspop_state_t;
endpackage

// ==== rtl/cspop_scoreboard.sv ====
// scoreboard bit array with sample-and-clear port
`timescale 1ns/1ps
`include "cspop_map.svh"
module cspop_scoreboard
  import cspop_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  input  wire logic                    pop,
  input  wire logic [`CSPOP_TGT_W-1:0] pop_idx,
  input  wire logic                    set_en,
  input  wire logic [`CSPOP_TGT_W-1:0] set_idx,
  output logic                         bit_q
);
  // ************************************************************
  // storage
  // ************************************************************
  // one bit per target address, no reset: array too big for flops
  logic sb_mem [0:`CSPOP_SB_DEPTH-1];
  logic bit_d;

  always_comb begin
    bit_d = bit_q;
    if (pop) begin
      bit_d = sb_mem[pop_idx];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_q <= 1'b0;
    end else if (ce) begin
      bit_q <= bit_d;
    end
  end

  // clear after sample; a set to the same index wins over the clear
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (pop) begin
        sb_mem[pop_idx] <= 1'b0;
      end
      if (set_en) begin
        sb_mem[set_idx] <= 1'b1;
      end
    end
  end
endmodule // cspop_scoreboard

// ==== rtl/cspop_unit.sv ====
// service-schedule pop execution unit
`timescale 1ns/1ps
`include "cspop_map.svh"
module cspop_unit
  import cspop_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire cspop_issue_t              issue,
  input  wire logic [31:0]               sched_config_register,
  input  wire logic                      sb_set_en,
  input  wire logic [`CSPOP_TGT_W-1:0]   sb_set_idx,
  input  wire logic [5:0]                src_reg_a,
  input  wire logic [5:0]                src_reg_b,
  input  wire logic                      src_use,
  input  wire logic                      fm_rvalid,
  input  wire logic [15:0]               fm_rdata,
  output logic                           busy_q,
  output logic                           stall_q,
  output logic                           fm_req_q,
  output logic [`CSPOP_ADDR_W:1]         fast_mem_halfword_address_q,
  output cspop_wb_t                      wb_q,
  output logic [7:0]                     external_status_register_q,
  output logic                           assigned_cell_status_bit_q
);
  // ************************************************************
  // decode and address forming
  // ************************************************************
  function automatic logic is_pop(input logic [31:0] ins);
    is_pop = (ins[`CSPOP_OP_HI:`CSPOP_OP_LO] == `CSPOP_OPCODE) &&
             (ins[`CSPOP_SUB_HI:`CSPOP_SUB_LO] == `CSPOP_SUB_POP);
  endfunction

  function automatic logic [`CSPOP_ADDR_W:1] form_addr(input logic [31:0] cfg,
                                                      input logic [`CSPOP_TGT_W-1:0] tgt);
    form_addr = {1'b0,
                 cfg[`CSPOP_CFG_BASE_HI:`CSPOP_CFG_BASE_LO],
                 tgt};
  endfunction

  function automatic logic [5:0] dest_of(input logic [31:0] ins);
    dest_of = ins[`CSPOP_RD_HI:`CSPOP_RD_LO];
  endfunction

  logic                    take;
  logic [`CSPOP_TGT_W-1:0] tgt;
  logic                    flag;

  assign tgt  = issue.rsb_value[`CSPOP_TGT_W-1:0];
  // destinations 32..63 are hardware registers; refused, not executed
  assign take = issue.valid && is_pop(issue.instr) &&
                (dest_of(issue.instr) < `CSPOP_RD_HW_LIMIT) && !busy_q;

  // ************************************************************
  // scoreboard
  // ************************************************************
  // sample and clear share the taking edge; the flag lags one cycle
  cspop_scoreboard u_sb (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .pop     (take),
    .pop_idx (tgt),
    .set_en  (sb_set_en),
    .set_idx (sb_set_idx),
    .bit_q   (flag)
  );

  // ************************************************************
  // sequencer
  // ************************************************************
  cspop_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CSPOP_IDLE: begin
        if (take) begin
          state_d = CSPOP_READ;
        end
      end
      CSPOP_READ: begin
        // no timeout: a lost memory answer keeps the unit busy until reset
        if (fm_rvalid) begin
          state_d = CSPOP_DONE;
        end
      end
      CSPOP_DONE: begin
        state_d = CSPOP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= CSPOP_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // fast memory request
  // ************************************************************
  logic [5:0]             rd_q, rd_d;
  logic                   fm_req_d;
  logic [`CSPOP_ADDR_W:1] addr_d;

  // address and destination hold until the next pop is taken
  always_comb begin
    rd_d     = rd_q;
    fm_req_d = 1'b0;
    addr_d   = fast_mem_halfword_address_q;
    if (take) begin
      rd_d     = dest_of(issue.instr);
      addr_d   = form_addr(sched_config_register, tgt);
      fm_req_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_q                        <= 6'h00;
      fm_req_q                    <= 1'b0;
      fast_mem_halfword_address_q <= '0;
    end else if (ce) begin
      rd_q                        <= rd_d;
      fm_req_q                    <= fm_req_d;
      fast_mem_halfword_address_q <= addr_d;
    end
  end

  // ************************************************************
  // destination write-back
  // ************************************************************
  cspop_wb_t wb_d;

  // the word is passed whole; no sign or zero handling of the identifier
  always_comb begin
    wb_d = '0;
    if ((state_q == CSPOP_READ) && fm_rvalid) begin
      wb_d.valid   = 1'b1;
      wb_d.rd      = rd_q;
      wb_d.conn_id = fm_rdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_q <= '0;
    end else if (ce) begin
      wb_q <= wb_d;
    end
  end

  // ************************************************************
  // assigned-cell flag and stall
  // ************************************************************
  logic acs_d;
  logic stall_d;
  logic hit;

  // stall only consumers of the pending destination, others run on
  assign hit = src_use && ((src_reg_a == rd_q) || (src_reg_b == rd_q));

  always_comb begin
    acs_d   = assigned_cell_status_bit_q;
    stall_d = 1'b0;
    if (state_q == CSPOP_READ) begin
      acs_d   = flag;
      stall_d = hit && !fm_rvalid;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      assigned_cell_status_bit_q <= 1'b0;
      stall_q                    <= 1'b0;
    end else if (ce) begin
      assigned_cell_status_bit_q <= acs_d;
      stall_q                    <= stall_d;
    end
  end

  // ************************************************************
  // status outputs
  // ************************************************************
  logic [7:0] esr_d;
  logic       busy_d;

  // status byte is rebuilt each cycle; only the flag bit carries meaning
  always_comb begin
    esr_d                   = 8'h00;
    esr_d[`CSPOP_STAT_BIT]  = acs_d;
    busy_d                  = (state_d != CSPOP_IDLE);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      external_status_register_q <= 8'h00;
      busy_q                     <= 1'b0;
    end else if (ce) begin
      external_status_register_q <= esr_d;
      busy_q                     <= busy_d;
    end
  end
endmodule // cspop_unit

// ==== dv/cspop_unit_asserts.sv ====
// assertion checker bound to the pop unit
`timescale 1ns/1ps
module cspop_unit_asserts
  import cspop_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst,
  input wire logic         ce,
  input wire cspop_issue_t issue,
  input wire logic [31:0]  sched_config_register,
  input wire logic         fm_rvalid,
  input wire logic [15:0]  fm_rdata,
  input wire logic         busy_q,
  input wire logic         stall_q,
  input wire logic         fm_req_q,
  input wire logic [19:1]  fast_mem_halfword_address_q,
  input wire cspop_wb_t    wb_q,
  input wire logic [7:0]   external_status_register_q,
  input wire logic         assigned_cell_status_bit_q
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // opcode, rd below 32 and sub-function zero in one compare
  a_decode_pop: assert property (ce && issue.valid && !busy_q &&
    {issue.instr[31:25], issue.instr[19:17]} == 10'h090 |=> fm_req_q) else $error("pop not decoded");
  a_addr_top: assert property (fm_req_q |-> !fast_mem_halfword_address_q[19]) else $error("bit 19 set");
  a_addr_base: assert property (fm_req_q |->
    fast_mem_halfword_address_q[18:15] == $past(sched_config_register[11:8])) else $error("base wrong");
  a_addr_target: assert property (fm_req_q |->
    fast_mem_halfword_address_q[14:1] == $past(issue.rsb_value[13:0])) else $error("target wrong");
  a_status_bit: assert property (external_status_register_q == {3'h0, assigned_cell_status_bit_q, 4'h0})
    else $error("status wrong");
  a_conn_write: assert property (busy_q && fm_rvalid |=>
    wb_q.valid && wb_q.conn_id == $past(fm_rdata) ##1 !wb_q.valid) else $error("write wrong");
  a_req_pulse: assert property (fm_req_q |=> !fm_req_q && busy_q) else $error("request not a pulse");
  a_stall_busy: assert property (stall_q |-> busy_q) else $error("stall while idle");
  c_hit: cover property (wb_q.valid && assigned_cell_status_bit_q);
  c_miss: cover property (wb_q.valid && !assigned_cell_status_bit_q);
  c_stall: cover property (stall_q);
endmodule // cspop_unit_asserts
bind cspop_unit cspop_unit_asserts u_chk (.mclk, .rst, .ce, .issue, .sched_config_register, .fm_rvalid,
  .fm_rdata, .busy_q, .stall_q, .fm_req_q, .fast_mem_halfword_address_q, .wb_q, .external_status_register_q,
  .assigned_cell_status_bit_q);

// ==== dv/cspop_fmem_model.sv ====
// fast memory stand-in answering table reads
`timescale 1ns/1ps
module cspop_fmem_model (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        fm_req_q,
  input wire logic [19:1] addr,
  input wire logic [2:0]  lat,
  output logic            fm_rvalid,
  output logic [15:0]     fm_rdata
);
  // ****
  // read answer
  // ****
  logic [2:0]  cnt;
  logic        pend;
  logic [19:1] a_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
      fm_rvalid <= 1'b0;
      fm_rdata <= 16'h0000;
    end else begin
      fm_rvalid <= 1'b0;
      // idle data toggles so a stale word never looks valid
      fm_rdata <= ~fm_rdata;
      if (fm_req_q) begin
        pend <= 1'b1;
        cnt <= lat;
        a_q <= addr;
      end else if (pend && cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end else if (pend) begin
        pend <= 1'b0;
        fm_rvalid <= 1'b1;
        fm_rdata <= a_q[16:1] ^ 16'ha5c3;
      end
    end
  end
endmodule // cspop_fmem_model

// ==== dv/cspop_unit_tb.sv ====
// self-checking bench for the pop unit
`timescale 1ns/1ps
module cspop_unit_tb
  import cspop_pkg::*;
();
  // ****
  // harness
  // ****
  logic         mclk = 1'b0, rst = 1'b1, sb_set_en = 1'b0, src_use = 1'b0, ce = 1'b1;
  logic [31:0]  cfg = '0;
  logic [13:0]  sb_set_idx = '0;
  logic [5:0]   src_a = '0, src_b = '0;
  logic [2:0]   lat = '0;
  cspop_issue_t issue = '0;
  logic         fm_rvalid, fm_req_q, busy_q, stall_q, flag;
  logic [15:0]  fm_rdata;
  logic [19:1]  addr;
  logic [7:0]   stat;
  cspop_wb_t    wb_q;
  int           n_errors = 0, comparisons = 0;
  initial forever #12.5 mclk = ~mclk;
  cspop_unit uut (.mclk, .rst, .ce, .issue, .sched_config_register(cfg), .sb_set_en, .sb_set_idx,
    .src_reg_a(src_a), .src_reg_b(src_b), .src_use, .fm_rvalid, .fm_rdata, .busy_q, .stall_q, .fm_req_q,
    .fast_mem_halfword_address_q(addr), .wb_q, .external_status_register_q(stat), .assigned_cell_status_bit_q(flag));
  cspop_fmem_model fmem (.mclk, .rst, .fm_req_q, .addr, .lat, .fm_rvalid, .fm_rdata);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic set_bit(input logic [13:0] idx);
    @(posedge mclk);
    sb_set_en <= 1'b1;
    sb_set_idx <= idx;
    @(posedge mclk);
    sb_set_en <= 1'b0;
  endtask
  // ca, cb: source registers of the consumer placed two slots after the pop
  task automatic pop(input logic [5:0] rd, input logic [13:0] idx, input logic [3:0] base, input logic hit,
                     input logic [5:0] ca, input logic [5:0] cb);
    logic [19:1] ea;
    int k;
    ea = {1'b0, base, idx};
    @(posedge mclk);
    cfg <= {20'h0_0000, base, 8'h00};
    issue <= '{1'b1, {6'h09, rd, 20'h0_0000}, {18'h0_0000, idx}};
    src_use <= 1'b0;
    @(posedge mclk);
    issue.valid <= 1'b0;
    #1;
    chk("request", 1'b1, fm_req_q);
    chk("address", ea, addr);
    @(posedge mclk);
    src_a <= ca;
    src_b <= cb;
    src_use <= 1'b1;
    #1;
    chk("flag", hit, flag);
    chk("status", {3'h0, hit, 4'h0}, stat);
    @(posedge mclk) #1;
    chk("stall", (ca == rd) || (cb == rd), stall_q);
    for (k = 0; k < 20 && wb_q.valid !== 1'b1; k++) @(posedge mclk) #1;
    chk("write", {1'b1, rd, ea[16:1] ^ 16'ha5c3}, {wb_q.valid, wb_q.rd, wb_q.conn_id});
    chk("stall end", 1'b0, stall_q);
    for (k = 0; k < 20 && busy_q !== 1'b0; k++) @(posedge mclk) #1;
  endtask
  // slow memory, then the same entry again must read as cleared
  task automatic t_hit_clear;
    @(posedge mclk);
    lat <= 3'h3;
    set_bit(14'h1234);
    pop(6'h05, 14'h1234, 4'h9, 1'b1, 6'h05, 6'h3f);
    pop(6'h05, 14'h1234, 4'h9, 1'b0, 6'h3f, 6'h05);
  endtask
  task automatic t_edges;
    @(posedge mclk);
    lat <= 3'h0;
    set_bit(14'h0000);
    set_bit(14'h3fff);
    pop(6'h1f, 14'h3fff, 4'hf, 1'b1, 6'h3e, 6'h3f);
    pop(6'h00, 14'h0000, 4'h0, 1'b1, 6'h00, 6'h00);
  endtask
  // clock enable low: a waiting pop must neither start nor clear its bit
  task automatic t_freeze;
    set_bit(14'h0abc);
    @(posedge mclk);
    ce <= 1'b0;
    issue <= '{1'b1, {6'h09, 6'h0a, 20'h0_0000}, 32'h0000_0abc};
    repeat (3) @(posedge mclk);
    #1 chk("frozen", 3'b000, {fm_req_q, busy_q, wb_q.valid});
    @(posedge mclk);
    ce <= 1'b1;
    issue.valid <= 1'b0;
    pop(6'h0a, 14'h0abc, 4'h3, 1'b1, 6'h3f, 6'h0a);
  endtask
  // fast variant, rd of 32 and a push opcode must all be ignored
  task automatic t_refuse;
    int k;
    for (k = 0; k < 3; k++) begin
      @(posedge mclk);
      issue <= '{1'b1, k == 0 ? {6'h09, 6'h03, 3'h1, 17'h0_0000} : k == 1 ? {6'h09, 6'h20, 20'h0_0000} :
        {6'h08, 6'h03, 20'h0_0000}, 32'h0000_0011};
      @(posedge mclk);
      issue.valid <= 1'b0;
      #1 chk("refused", 2'b00, {fm_req_q, busy_q});
    end
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_hit_clear;
    t_edges;
    t_refuse;
    t_freeze;
    report_and_stop;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    report_and_stop;
  end
endmodule // cspop_unit_tb
